/* design/exception_lowpower_control.sv */
// exception arbitration, break handling and wait/stop sequencing
//
// Function
// - stop instruction clears recovery counter and holds it until recovery starts.
// - wake samples short recovery select: 32 crystal cycles if set, else 4096.
// - external reset pin leaves recovery counter value and counting untouched.
// - after every reset state the recovery counter counts each crystal cycle.
// - interrupt entry pushes registers and sets mask; return pops them.
// - requests are latched and arbitrated at processing start; vector code held.
// - latched interrupt is not displaced until serviced or mask cleared.
// - while running, hardware interrupts checked only at instruction end, if unmasked and enabled.
// - with several pending, the highest priority source is serviced first.
// - pending interrupt at return is taken before main code; prefetch discarded.
// - interrupt entry never pushes the high index register.
// - software interrupt instruction is taken whatever the mask state.
// - software interrupt stacks pc; hardware interrupt stacks pc minus one.
// - every reset source beats all interrupts and skips arbitration.
// - break request forces the cpu to the software interrupt vector.
// - in break, status flags only clear when flag clear enable is set.
// - a flag cleared during break stays cleared after break ends.
// - two-step flag clears stay blocked in break; second step works after.
// - wait or stop stops cpu clock and clears the interrupt mask.
// - wait keeps peripheral clocks; interrupt stacking starts one cycle later.
// - wait also ends on reset or break; break in wait sets break wait flag.
// - stop gates base and crystal clocks; stacking waits for recovery time.
// - break wait flag cleared by writing zero and by reset.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module exception_lowpower_control
	import exc_lp_pkg::*;
#(
	parameter int N_IRQ        = 8,
	parameter int XTAL_DIV     = XTAL_DIV_DEF,
	parameter int REC_LONG     = REC_LONG_CYC,
	parameter int REC_SHORT    = REC_SHORT_CYC
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output var  logic [DATA_W-1:0] reg_rdata,
	// cpu status
	input  wire logic              instr_done,
	input  wire logic              cpu_imask,
	input  wire logic              swi_exec,
	input  wire logic              rti_exec,
	input  wire logic              wait_exec,
	input  wire logic              stop_exec,
	// event sources
	input  wire logic [N_IRQ-1:0]  irq_req,
	input  wire logic [N_IRQ-1:0]  irq_en,
	input  wire logic              break_req,
	input  wire logic              ext_reset,
	input  wire logic              int_reset,
	// cpu control
	output var  logic              int_start,
	output var  logic              push_regs,
	output var  logic              push_index_high,
	output var  logic              stack_pc_minus1,
	output var  logic              set_imask,
	output var  logic              clear_imask,
	output var  logic              pop_regs,
	output var  logic              discard_prefetch,
	output var  logic [VEC_W-1:0]  vector_sel,
	output var  logic              reset_vector,
	// clock gating
	output var  logic              cpu_clk_en,
	output var  logic              periph_clk_en,
	output var  logic              base_clock_out_en,
	output var  logic              crystal_clock_en,
	// break and flag protection
	output var  logic              break_state,
	output var  logic              flag_clear_allow
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed
	{
		ctl_state_e        st;
		wake_cause_e       cause;
		logic [DIV_W-1:0]  div;
		logic              tick;
		logic              cnt_clr;
		logic              rec_short;
		logic              latched;
		logic [VEC_W-1:0]  lat_vec;
		logic              lat_pcm1;
		logic              imask_prev;
		logic              break_wait_flag;
		logic              break_flag_clear_enable;
		logic              short_recovery_select;
		logic              brk;
		logic [DATA_W-1:0] rdata;
		logic              int_start;
		logic              push_regs;
		logic              push_hi;
		logic              pcm1;
		logic              set_im;
		logic              clr_im;
		logic              pop;
		logic              discard;
		logic [VEC_W-1:0]  vec;
		logic              rst_vec;
		logic              cpu_en;
		logic              per_en;
		logic              base_en;
		logic              xtal_en;
		logic              allow;
	} ctl_s;

	ctl_s             q;
	ctl_s             d;
	logic [CNT_W-1:0] rec_count;
	logic [N_IRQ-1:0] pend;
	logic             any_pend;
	logic [VEC_W-1:0] top_vec;
	logic             rec_done;

	// ---------------------------------------------------------------
	// recovery counter
	// ---------------------------------------------------------------
	recovery_counter #(
		.W      (CNT_W)
	) u_rec_cnt (
		.clk    (clk),
		.resetn (resetn),
		.tick   (q.tick),
		.clear  (q.cnt_clr),
		.count  (rec_count)
	);

	// ---------------------------------------------------------------
	// arbitration
	// ---------------------------------------------------------------
	always_comb
	begin
		pend     = irq_req & irq_en;
		any_pend = |pend;
		top_vec  = '0;
		for (int i = N_IRQ - 1; i >= 0; i--)
		begin
			if (pend[i])
				top_vec = VEC_W'(i);
		end
		if (q.rec_short)
			rec_done = q.tick && (rec_count == CNT_W'(REC_SHORT - 1));
		else
			rec_done = q.tick && (rec_count == CNT_W'(REC_LONG - 1));
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.int_start  = 1'b0;
		d.push_regs  = 1'b0;
		d.push_hi    = 1'b0;
		d.set_im     = 1'b0;
		d.clr_im     = 1'b0;
		d.pop        = 1'b0;
		d.discard    = 1'b0;
		d.rst_vec    = 1'b0;
		d.imask_prev = cpu_imask;

		// crystal-rate enable, stops with the crystal clock
		d.tick = 1'b0;
		if (q.xtal_en)
		begin
			if (q.div == DIV_W'(XTAL_DIV - 1))
			begin
				d.div  = '0;
				d.tick = 1'b1;
			end
			else
				d.div = DIV_W'(q.div + 1'b1);
		end

		// register port
		d.rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				ADDR_BREAK_STATUS: d.rdata[BW_BIT]    = q.break_wait_flag;
				ADDR_BREAK_FLAG:   d.rdata[BREAK_FLAG_CLEAR_ENABLE_BIT]  = q.break_flag_clear_enable;
				ADDR_CONFIG:       d.rdata[SHORT_RECOVERY_SELECT_BIT] = q.short_recovery_select;
				ADDR_CORE_STATUS:  d.rdata = {q.brk, q.latched, q.lat_vec[1:0], 1'b0, 3'(q.st)};
				default:           d.rdata = '0;
			endcase
		end
		if (reg_wr)
		begin
			case (reg_addr)
				ADDR_BREAK_STATUS:
				begin
					if (!reg_wdata[BW_BIT])
						d.break_wait_flag = 1'b0;
				end
				ADDR_BREAK_FLAG:   d.break_flag_clear_enable = reg_wdata[BREAK_FLAG_CLEAR_ENABLE_BIT];
				ADDR_CONFIG:       d.short_recovery_select   = reg_wdata[SHORT_RECOVERY_SELECT_BIT];
				default:           d.rdata = d.rdata;
			endcase
		end

		// mask cleared drops the latch so arbitration reopens
		if (q.imask_prev && !cpu_imask && q.st == ST_RUN)
			d.latched = 1'b0;

		// internal resets clear the counter, external does not
		d.cnt_clr = int_reset || q.st == ST_STOP;

		if (rti_exec && q.st == ST_RUN)
		begin
			d.pop = 1'b1;
			if (q.brk)
				d.brk = 1'b0;
			if (any_pend)
				d.discard = 1'b1;
		end

		case (q.st)
			ST_RUN:
			begin
				if (instr_done)
				begin
					if (break_req)
					begin
						d.brk      = 1'b1;
						d.latched  = 1'b1;
						d.lat_vec  = VEC_SWI;
						d.lat_pcm1 = 1'b0;
						d.st       = ST_STACK;
					end
					else if (swi_exec)
					begin
						d.latched  = 1'b1;
						d.lat_vec  = VEC_SWI;
						d.lat_pcm1 = 1'b0;
						d.st       = ST_STACK;
					end
					else if (wait_exec)
					begin
						d.clr_im = 1'b1;
						d.cpu_en = 1'b0;
						d.st     = ST_WAIT;
					end
					else if (stop_exec)
					begin
						d.clr_im  = 1'b1;
						d.cpu_en  = 1'b0;
						d.per_en  = 1'b0;
						d.base_en = 1'b0;
						d.xtal_en = 1'b0;
						d.div     = '0;
						d.latched = 1'b0;
						d.st      = ST_STOP;
					end
					else if (q.latched)
						d.st = ST_STACK;
					else if (!cpu_imask && any_pend)
					begin
						d.latched  = 1'b1;
						d.lat_vec  = top_vec;
						d.lat_pcm1 = 1'b1;
						d.st       = ST_STACK;
					end
				end
			end
			ST_STACK:
			begin
				d.int_start = 1'b1;
				d.push_regs = 1'b1;
				d.set_im    = 1'b1;
				d.vec       = q.lat_vec;
				d.pcm1      = q.lat_pcm1;
				d.latched   = 1'b0;
				d.st        = ST_RUN;
			end
			ST_WAIT:
			begin
				if (break_req)
				begin
					d.break_wait_flag = 1'b1;
					d.brk      = 1'b1;
					d.cpu_en   = 1'b1;
					d.latched  = 1'b1;
					d.lat_vec  = VEC_SWI;
					d.lat_pcm1 = 1'b0;
					d.st       = ST_STACK;
				end
				else if (any_pend)
				begin
					d.cpu_en   = 1'b1;
					d.latched  = 1'b1;
					d.lat_vec  = top_vec;
					d.lat_pcm1 = 1'b1;
					d.st       = ST_STACK;
				end
			end
			ST_STOP:
			begin
				if (break_req || any_pend)
				begin
					d.rec_short = q.short_recovery_select;
					d.cause     = break_req ? WAKE_BRK : WAKE_INT;
					d.xtal_en   = 1'b1;
					d.cnt_clr   = 1'b0;
					d.st        = ST_RECOVER;
				end
			end
			ST_RECOVER:
			begin
				if (rec_done)
				begin
					d.cpu_en  = 1'b1;
					d.per_en  = 1'b1;
					d.base_en = 1'b1;
					d.st      = ST_RUN;
					case (q.cause)
						WAKE_RST:
						begin
							d.rst_vec = 1'b1;
							d.vec     = VEC_RESET;
						end
						WAKE_BRK:
						begin
							d.brk      = 1'b1;
							d.latched  = 1'b1;
							d.lat_vec  = VEC_SWI;
							d.lat_pcm1 = 1'b0;
							d.st       = ST_STACK;
						end
						default:
						begin
							if (any_pend)
							begin
								d.latched  = 1'b1;
								d.lat_vec  = top_vec;
								d.lat_pcm1 = 1'b1;
								d.st       = ST_STACK;
							end
						end
					endcase
				end
			end
			default: d.st = ST_RUN;
		endcase

		// any reset source wins over every interrupt
		if (ext_reset || int_reset)
		begin
			d.latched   = 1'b0;
			d.brk       = 1'b0;
			d.int_start = 1'b0;
			d.push_regs = 1'b0;
			d.set_im    = 1'b0;
			if (q.st == ST_STOP || q.st == ST_RECOVER)
			begin
				d.rec_short = q.short_recovery_select;
				d.cause     = WAKE_RST;
				d.xtal_en   = 1'b1;
				d.cnt_clr   = int_reset;
				d.st        = ST_RECOVER;
			end
			else
			begin
				d.rst_vec = 1'b1;
				d.vec     = VEC_RESET;
				d.cpu_en  = 1'b1;
				d.st      = ST_RUN;
			end
		end

		d.allow = !d.brk || d.break_flag_clear_enable;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			q                         <= '0;
			q.st                      <= ST_RUN;
			q.cause                   <= WAKE_INT;
			q.vec                     <= VEC_RESET;
			q.rdata                   <= RESET_BYTE;
			q.cpu_en                  <= 1'b1;
			q.per_en                  <= 1'b1;
			q.base_en                 <= 1'b1;
			q.xtal_en                 <= 1'b1;
			q.allow                   <= 1'b1;
			q.imask_prev              <= 1'b1;
			q.break_wait_flag         <= 1'b0;
		end
		else
			q <= d;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign reg_rdata         = q.rdata;
	assign int_start         = q.int_start;
	assign push_regs         = q.push_regs;
	assign push_index_high   = q.push_hi;
	assign stack_pc_minus1   = q.pcm1;
	assign set_imask         = q.set_im;
	assign clear_imask       = q.clr_im;
	assign pop_regs          = q.pop;
	assign discard_prefetch  = q.discard;
	assign vector_sel        = q.vec;
	assign reset_vector      = q.rst_vec;
	assign cpu_clk_en        = q.cpu_en;
	assign periph_clk_en     = q.per_en;
	assign base_clock_out_en = q.base_en;
	assign crystal_clock_en  = q.xtal_en;
	assign break_state       = q.brk;
	assign flag_clear_allow  = q.allow;

endmodule
`default_nettype wire

/* design/exc_lp_pkg.sv */
// constants shared by the exception and low-power control block
package exc_lp_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int           ADDR_W             = 4;
	localparam int           DATA_W             = 8;
	localparam logic [3:0]   ADDR_BREAK_STATUS  = 4'h0;
	localparam logic [3:0]   ADDR_BREAK_FLAG    = 4'h1;
	localparam logic [3:0]   ADDR_CONFIG        = 4'h2;
	localparam logic [3:0]   ADDR_CORE_STATUS   = 4'h3;
	localparam int           BW_BIT             = 1;
	localparam int           BREAK_FLAG_CLEAR_ENABLE_BIT           = 7;
	localparam int           SHORT_RECOVERY_SELECT_BIT          = 0;
	localparam logic [7:0]   RESET_BYTE         = 8'h00;

	// ---------------------------------------------------------------
	// recovery timing in crystal clock cycles
	// ---------------------------------------------------------------
	localparam int           CNT_W              = 12;
	localparam int           REC_SHORT_CYC      = 32;
	localparam int           REC_LONG_CYC       = 4096;
	localparam int           XTAL_DIV_DEF       = 4;
	localparam int           DIV_W              = 8;

	// ---------------------------------------------------------------
	// vector codes handed to the cpu
	// ---------------------------------------------------------------
	localparam int           VEC_W              = 5;
	localparam logic [4:0]   VEC_SWI            = 5'h1E;
	localparam logic [4:0]   VEC_RESET          = 5'h1F;

	typedef enum logic [2:0] {ST_RUN, ST_STACK, ST_WAIT, ST_STOP, ST_RECOVER} ctl_state_e;
	typedef enum logic [1:0] {WAKE_INT, WAKE_BRK, WAKE_RST} wake_cause_e;

endpackage

/* design/recovery_counter.sv */
// free-running crystal-rate counter used to time stop recovery
`timescale 1ns/1ps
`default_nettype none
module recovery_counter
	import exc_lp_pkg::*;
#(
	parameter int W = CNT_W
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// control
	input  wire logic         tick,
	input  wire logic         clear,
	// count
	output var  logic [W-1:0] count
);

	typedef struct packed
	{
		logic [W-1:0] cnt;
	} cnt_s;

	cnt_s q;
	cnt_s d;

	always_comb
	begin
		d = q;
		if (clear)
			d.cnt = '0;
		else if (tick)
			d.cnt = W'(q.cnt + 1'b1);
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			q <= '0;
		else
			q <= d;
	end

	assign count = q.cnt;

endmodule
`default_nettype wire

/* testbench/exc_lp_checker.sv */
// port assertions for the exception and low-power control block
`timescale 1ns/1ps
`default_nettype none
module exc_lp_checker
	import exc_lp_pkg::*;
#(
	parameter int N_IRQ = 8
)
(
	// clock and reset
	input wire logic             clk,
	input wire logic             resetn,
	// cpu and sources
	input wire logic             instr_done,
	input wire logic             cpu_imask,
	input wire logic             swi_exec,
	input wire logic             wait_exec,
	input wire logic             stop_exec,
	input wire logic [N_IRQ-1:0] irq_req,
	input wire logic [N_IRQ-1:0] irq_en,
	input wire logic             break_req,
	input wire logic             ext_reset,
	input wire logic             int_reset,
	// cpu control
	input wire logic             int_start,
	input wire logic             push_regs,
	input wire logic             push_index_high,
	input wire logic             stack_pc_minus1,
	input wire logic             set_imask,
	input wire logic             clear_imask,
	input wire logic [VEC_W-1:0] vector_sel,
	input wire logic             reset_vector,
	// clocks and break
	input wire logic             cpu_clk_en,
	input wire logic             periph_clk_en,
	input wire logic             base_clock_out_en,
	input wire logic             crystal_clock_en,
	input wire logic             break_state,
	input wire logic             flag_clear_allow
);
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic run_end;
	assign run_end = instr_done && cpu_clk_en && !break_req && !ext_reset && !int_reset;

	AST_NO_INDEX_HIGH: assert property (!push_index_high)
		else $error("index high pushed");
	AST_ENTRY_PUSH: assert property (int_start |-> push_regs && set_imask)
		else $error("entry without push and mask");
	AST_SWI_PC: assert property (int_start && vector_sel == VEC_SWI |-> !stack_pc_minus1)
		else $error("swi stacked pc minus one");
	AST_HW_PC: assert property (int_start && vector_sel < N_IRQ |-> stack_pc_minus1)
		else $error("hw entry stacked plain pc");
	AST_SWI_TAKEN: assert property (run_end && swi_exec |-> ##2 int_start && vector_sel == VEC_SWI)
		else $error("swi not taken");
	AST_TOP_PRIO: assert property (run_end && !swi_exec && !wait_exec && !stop_exec && !cpu_imask
		&& irq_req[0] && irq_en[0] |-> ##2 int_start && vector_sel == 5'h00)
		else $error("top source not taken");
	AST_WAIT_ENTRY: assert property (run_end && wait_exec && !swi_exec
		|=> clear_imask && !cpu_clk_en && periph_clk_en)
		else $error("wait entry wrong");
	AST_STOP_CLOCKS: assert property (run_end && stop_exec && !swi_exec && !wait_exec
		|=> !base_clock_out_en && !crystal_clock_en && !cpu_clk_en)
		else $error("stop clocks still on");
	AST_FLAG_FREE: assert property (!break_state && !$past(break_state) |-> flag_clear_allow)
		else $error("flags locked outside break");
	AST_RESET_FIRST: assert property ($rose(ext_reset) && cpu_clk_en |=> reset_vector && !int_start)
		else $error("reset not first");
endmodule

bind exception_lowpower_control exc_lp_checker #(.N_IRQ(N_IRQ)) chk_i (.clk, .resetn, .instr_done,
	.cpu_imask, .swi_exec, .wait_exec, .stop_exec, .irq_req, .irq_en, .break_req, .ext_reset,
	.int_reset, .int_start, .push_regs, .push_index_high, .stack_pc_minus1, .set_imask, .clear_imask,
	.vector_sel, .reset_vector, .cpu_clk_en, .periph_clk_en, .base_clock_out_en, .crystal_clock_en,
	.break_state, .flag_clear_allow);
`default_nettype wire

/* testbench/cpu_core_model.sv */
// behavioural cpu core facing the exception block
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
(
	// clock and control from the block
	input  wire logic clk,
	input  wire logic set_imask,
	input  wire logic clear_imask,
	input  wire logic pop_regs,
	// instruction status
	output var  logic instr_done,
	output var  logic swi_exec,
	output var  logic wait_exec,
	output var  logic stop_exec,
	output var  logic rti_exec,
	output var  logic cpu_imask
);
	// ---------------------------------------------------------------
	// mask bit and instruction steps
	// ---------------------------------------------------------------
	initial
	begin
		{instr_done, swi_exec, wait_exec, stop_exec, rti_exec, cpu_imask} = 6'h00;
	end
	always @(posedge clk)
		if (set_imask) cpu_imask <= 1'b1;
		else if (clear_imask || pop_regs) cpu_imask <= 1'b0;
	task set_mask(input logic m);
		@(posedge clk);
		@(posedge clk);
		cpu_imask <= m;
	endtask
	// kind 0 plain, 1 swi, 2 wait, 3 stop
	task step(input int k);
		@(posedge clk);
		{instr_done, swi_exec, wait_exec, stop_exec} <= {1'b1, k == 1, k == 2, k == 3};
		@(posedge clk);
		{instr_done, swi_exec, wait_exec, stop_exec} <= 4'h0;
	endtask
	task return_from_interrupt;
		@(posedge clk);
		rti_exec <= 1'b1;
		@(posedge clk);
		rti_exec <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* testbench/exception_lowpower_control_test.sv */
// self-checking bench for the exception and low-power control block
`timescale 1ns/1ps
`default_nettype none
module exception_lowpower_control_test;
	import exc_lp_pkg::*;
	localparam int XD = 2;
	localparam int RL = 64;
	logic clk, resetn, reg_wr, reg_rd, break_req, ext_reset, int_reset, rd_seen = 1'b0;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, irq_req, irq_en, rv;
	logic instr_done, cpu_imask, swi_exec, rti_exec, wait_exec, stop_exec, int_start, push_regs;
	logic set_imask, clear_imask, pop_regs, discard_prefetch, reset_vector, stack_pc_minus1;
	logic cpu_clk_en, periph_clk_en, crystal_clock_en, break_state, flag_clear_allow;
	logic push_index_high, base_clock_out_en;
	logic [4:0] vector_sel;
	logic [5:0] e;
	logic [7:0] rq[$];
	logic [5:0] iq[$];
	int n_errors = 0, cmp_count = 0, cyc = 0, n, i;

	exception_lowpower_control #(.XTAL_DIV(XD), .REC_LONG(RL)) uut (.clk, .resetn, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_done, .cpu_imask, .swi_exec, .rti_exec,
		.wait_exec, .stop_exec, .irq_req, .irq_en, .break_req, .ext_reset, .int_reset, .int_start,
		.push_regs, .push_index_high, .stack_pc_minus1, .set_imask, .clear_imask, .pop_regs,
		.discard_prefetch, .vector_sel, .reset_vector, .cpu_clk_en, .periph_clk_en,
		.base_clock_out_en, .crystal_clock_en, .break_state, .flag_clear_allow);
	cpu_core_model cpu (.clk, .set_imask, .clear_imask, .pop_regs, .instr_done, .swi_exec,
		.wait_exec, .stop_exec, .rti_exec, .cpu_imask);

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task chk(input string nm, input logic [7:0] x, input logic [7:0] s);
		cmp_count++;
		if (s !== x)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, s);
		end
	endtask
	task final_report;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] x);
		rq.push_back(x);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task wait_start(input int lim);
		n = 0;
		while (int_start !== 1'b1 && n < lim)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task hw(input logic [7:0] r, input logic [7:0] en, input logic m);
		cpu.set_mask(m);
		{irq_req, irq_en} <= {r, en};
		cpu.step(0);
		for (i = 7; i >= 0; i--)
			if (r[i] && en[i]) e = {1'b1, i[4:0]};
		if (!m && (r & en) != 0) iq.push_back(e);
		repeat (4) @(posedge clk);
		irq_req <= 8'h00;
		cpu.return_from_interrupt;
	endtask

	// ---------------------------------------------------------------
	// result monitor and timeout
	// ---------------------------------------------------------------
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			final_report;
		end
		if (rd_seen) chk("reg_rdata", rq.pop_front(), reg_rdata);
		rd_seen <= reg_rd;
		if (int_start === 1'b1 && iq.size() == 0) chk("unexpected int_start", 8'h00, 8'h01);
		else if (int_start === 1'b1)
		begin
			chk("entry", {2'b00, iq.pop_front()}, {1'b0, push_index_high, stack_pc_minus1, vector_sel});
		end
	end

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		{resetn, reg_wr, reg_rd, break_req, ext_reset, int_reset} = 6'h00;
		{reg_addr, reg_wdata, irq_req, irq_en} = 28'h0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		void'($urandom(32'h48B5314E));
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		wr(4'h1, 8'h80);
		rd(4'h1, 8'h80);
		wr(4'h1, 8'h00);
		hw(8'h09, 8'hFF, 1'b0);
		hw(8'h09, 8'hFE, 1'b0);
		hw(8'h0F, 8'hFF, 1'b1);
		for (int k = 0; k < 8; k++) hw(8'($urandom), 8'($urandom), 1'($urandom));
		cpu.set_mask(1'b1);
		cpu.step(1);
		iq.push_back({1'b0, VEC_SWI});
		repeat (4) @(posedge clk);
		irq_req <= 8'h02;
		irq_en <= 8'hFF;
		cpu.return_from_interrupt;
		#1 chk("pop and discard", 8'h03, {6'h0, pop_regs, discard_prefetch});
		iq.push_back(6'h21);
		cpu.step(0);
		repeat (4) @(posedge clk);
		irq_req <= 8'h00;
		cpu.return_from_interrupt;
		cpu.step(2);
		repeat (3) @(posedge clk);
		#1 chk("wait clocks", 8'h01, {6'h0, cpu_clk_en, periph_clk_en});
		@(posedge clk);
		irq_req <= 8'h04;
		iq.push_back(6'h22);
		wait_start(10);
		chk("wait wake cycles", 8'h01, {7'h0, n <= 3});
		@(posedge clk);
		irq_req <= 8'h00;
		cpu.return_from_interrupt;
		cpu.step(2);
		repeat (3) @(posedge clk);
		break_req <= 1'b1;
		iq.push_back({1'b0, VEC_SWI});
		wait_start(10);
		repeat (2) @(posedge clk);
		#1 chk("break and allow", 8'h02, {6'h0, break_state, flag_clear_allow});
		rd(4'h0, 8'h02);
		wr(4'h0, 8'h00);
		rd(4'h0, 8'h00);
		wr(4'h1, 8'h80);
		repeat (2) @(posedge clk);
		#1 chk("allow with enable", 8'h01, {7'h0, flag_clear_allow});
		wr(4'h1, 8'h00);
		break_req <= 1'b0;
		cpu.return_from_interrupt;
		repeat (2) @(posedge clk);
		#1 chk("break_state", 8'h00, {7'h0, break_state});
		for (int s = 1; s >= 0; s--)
		begin
			wr(4'h2, s[7:0]);
			cpu.step(3);
			repeat (5) @(posedge clk);
			#1 chk("stop clocks", 8'h00, {6'h0, base_clock_out_en, crystal_clock_en});
			@(posedge clk);
			irq_req <= 8'h01;
			iq.push_back(6'h20);
			wait_start(400);
			rv = (s == 1) ? 8'(REC_SHORT_CYC * XD) : 8'(RL * XD);
			chk("recovery in time", 8'h01, {7'h0, n >= rv && n <= rv + 8});
			@(posedge clk);
			irq_req <= 8'h00;
			cpu.return_from_interrupt;
		end
		@(posedge clk);
		ext_reset <= 1'b1;
		@(posedge clk);
		ext_reset <= 1'b0;
		#1 chk("reset vector", 8'h3F, {2'b00, reset_vector, vector_sel});
		repeat (4) @(posedge clk);
		int_reset <= 1'b1;
		@(posedge clk);
		int_reset <= 1'b0;
		#1 chk("int reset vector", 8'h02, {6'h0, reset_vector, int_start});
		cpu.step(3);
		repeat (3) @(posedge clk);
		int_reset <= 1'b1;
		@(posedge clk);
		int_reset <= 1'b0;
		n = 0;
		while (reset_vector !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("reset recovery", 8'h01, {7'h0, n >= RL * XD && n <= RL * XD + 8});
		chk("reset recovery vector", 8'h1F, {3'h0, vector_sel});
		repeat (4) @(posedge clk);
		chk("notes left", 8'h00, 8'(iq.size()));
		final_report;
	end
endmodule
`default_nettype wire
